// File: src/rtcpi_cfg.svh
// Purpose: constants of the rtc periodic interrupt logic
// Assumes: 25 MHz system clock, byte wide register port
// Notes: times are kept in ns, cycle counts derive from them
//
// Summary of operation
// - run bit rising starts countdown from preset
// - counter reloads preset after each event
// - wakeup event sets hit flag, held until zeroed
// - wakeup drives line low only when mask set
// - line low for release span, then released
// - run bit zero stops timer, releases line
// - clearing hit flag leaves line unchanged
// - clearing countdown mask releases line at once
// - update event each second or minute by choice
// - choice sets wakeup span: 500 ms or 7.813 ms
// - update event sets tick flag, held until zeroed
// - writing one to tick flag is ignored
// - update drives line low only when mask set
// - update line low at most 7.813 ms
// - clearing tick flag does not release line
// - clearing tick mask releases line at once
// - control reset bit set blocks update events
// - update function runs regardless of mask
// - line shared, other enabled source may hold
// - fixed zero bits are read-only zero
// - countdown starts at write completing run bit
`ifndef RTCPI_CFG_SVH
`define RTCPI_CFG_SVH

`define RTCPI_ADDR_CTRL1 8'h0d
`define RTCPI_ADDR_FLAGS 8'h0e
`define RTCPI_ADDR_CTRL2 8'h0f

`define RTCPI_BIT_TICK_SEL 5
`define RTCPI_BIT_RUN 4
`define RTCPI_BIT_TICK_FLAG 5
`define RTCPI_BIT_HIT_FLAG 4
`define RTCPI_BIT_TICK_MASK 5
`define RTCPI_BIT_CD_MASK 4
`define RTCPI_BIT_CTRL_RESET 0

`define RTCPI_CTRL1_RESET 8'h00
`define RTCPI_CTRL2_RESET 8'h40
`define RTCPI_CTRL2_WMASK 8'hf9

`define RTCPI_CLK_NS 40
`define RTCPI_SPAN_LONG_NS 500000000
`define RTCPI_SPAN_SHORT_NS 7813000
`define RTCPI_CNT_W 24

`endif

// File: src/rtcpi_pkg.sv
// Purpose: shared types of the rtc periodic interrupt logic
// Assumes: nothing beyond the cfg header
// Notes: values live in rtcpi_cfg.svh
package rtcpi_pkg;

  typedef logic [7:0] rtcpi_byte_t;

  typedef enum logic {
    TICK_SECOND = 1'b0,
    TICK_MINUTE = 1'b1
  } rtcpi_tick_e;

endpackage

// File: src/rtcpi_span.sv
// Purpose: auto release span timer for one interrupt source
// Assumes: start and cancel are same-clock signals
// Notes: cancel outranks start
`timescale 1ns/100ps

module rtcpi_span #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] span_cyc,
  // status
  output logic active
);

  typedef struct packed {
    logic act;
    logic [W-1:0] cnt;
  } rtcpi_span_s;

  rtcpi_span_s s_q;
  rtcpi_span_s s_d;

  generate
    if (W < 2) begin : g_bad_width
      $error("rtcpi_span: width too small");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    if (cancel) begin
      s_d.act = 1'b0;
      s_d.cnt = '0;
    end else if (start) begin
      // a new event restarts the full span
      s_d.act = 1'b1;
      s_d.cnt = span_cyc;
    end else if (s_q.act) begin
      if (s_q.cnt <= W'(1)) begin
        s_d.act = 1'b0;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.act;

  ////////////////////////////////////////////////////////////////////////
  a_span_start: assert property (@(posedge clk) disable iff (rst)
    (start && !cancel) |=> active) else $error("span did not start");

endmodule // rtcpi_span

// File: src/rtcpi_top.sv
// Purpose: wakeup countdown and time update interrupt logic with shared open-drain line
// Assumes: register port driven by a serial slave engine on clk; ticks are one-cycle pulses on clk
// Notes: line output enable is active low; pin level is always zero when enabled
`timescale 1ns/100ps
`include "rtcpi_cfg.svh"

module rtcpi_top #(
  parameter int CNT_W = `RTCPI_CNT_W,
  parameter int SPAN_LONG_CYC = `RTCPI_SPAN_LONG_NS / `RTCPI_CLK_NS,
  parameter int SPAN_SHORT_CYC = (`RTCPI_SPAN_SHORT_NS + `RTCPI_CLK_NS - 1) / `RTCPI_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial slave engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire rtcpi_pkg::rtcpi_byte_t reg_addr,
  input wire rtcpi_pkg::rtcpi_byte_t reg_wdata,
  output rtcpi_pkg::rtcpi_byte_t reg_rdata,
  output logic reg_rvalid,
  // timekeeping inputs
  input wire logic [CNT_W-1:0] preset_value,
  input wire logic timer_src_tick,
  input wire logic second_tick,
  input wire logic minute_tick,
  // open-drain interrupt line
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_oe_n,
  // event pulses
  output logic wakeup_event,
  output logic update_event
);

  import rtcpi_pkg::*;

  localparam int SPAN_W = CNT_W;

  typedef struct packed {
    rtcpi_byte_t ctrl1;
    rtcpi_byte_t ctrl2;
    logic clock_tick_flag;
    logic countdown_hit_flag;
    logic [CNT_W-1:0] cnt;
    rtcpi_byte_t rdata;
    logic rvalid;
    logic oe_n;
    logic pin_lvl;
    logic wk_evt;
    logic up_evt;
    logic pin_s1;
    logic pin_s2;
  } rtcpi_top_s;

  rtcpi_top_s s_q;
  rtcpi_top_s s_d;

  logic countdown_run_bit;
  logic countdown_irq_mask;
  logic clock_tick_irq_mask;
  logic ctrl_reset_bit;
  rtcpi_tick_e tick_period_choice;
  logic run_rise;
  logic tmr_evt;
  logic upd_evt;
  logic tmr_active;
  logic upd_active;
  logic tmr_cancel;
  logic upd_cancel;
  logic [SPAN_W-1:0] tmr_span;
  logic [SPAN_W-1:0] upd_span;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  generate
    if (CNT_W < 2 || CNT_W > 24) begin : g_bad_cnt
      $error("rtcpi_top: counter width out of range");
    end
    if (SPAN_LONG_CYC < 1 || SPAN_SHORT_CYC < 1) begin : g_bad_span
      $error("rtcpi_top: release span below one cycle");
    end
    if (SPAN_LONG_CYC >= (1 << SPAN_W) || SPAN_SHORT_CYC >= (1 << SPAN_W)) begin : g_wide_span
      $error("rtcpi_top: release span does not fit counter");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // field views

  assign countdown_run_bit = s_q.ctrl1[`RTCPI_BIT_RUN];
  assign tick_period_choice = rtcpi_tick_e'(s_q.ctrl1[`RTCPI_BIT_TICK_SEL]);
  assign countdown_irq_mask = s_q.ctrl2[`RTCPI_BIT_CD_MASK];
  assign clock_tick_irq_mask = s_q.ctrl2[`RTCPI_BIT_TICK_MASK];
  assign ctrl_reset_bit = s_q.ctrl2[`RTCPI_BIT_CTRL_RESET];

  ////////////////////////////////////////////////////////////////////////
  // release span timers, one per source

  // span follows the tick period choice for the wakeup source
  assign tmr_span = (tick_period_choice == TICK_MINUTE) ?
                    SPAN_W'(SPAN_SHORT_CYC) : SPAN_W'(SPAN_LONG_CYC);
  assign upd_span = SPAN_W'(SPAN_SHORT_CYC);

  // mask drop cancels either span, stop cancels the wakeup span only; flag clears do not touch it
  assign tmr_cancel = !countdown_irq_mask || !countdown_run_bit;
  assign upd_cancel = !clock_tick_irq_mask;

  rtcpi_span #(
    .W(SPAN_W)
  ) u_tmr_span (
    .clk(clk),
    .rst(rst),
    .start(tmr_evt && countdown_irq_mask),
    .cancel(tmr_cancel),
    .span_cyc(tmr_span),
    .active(tmr_active)
  );

  rtcpi_span #(
    .W(SPAN_W)
  ) u_upd_span (
    .clk(clk),
    .rst(rst),
    .start(upd_evt && clock_tick_irq_mask),
    .cancel(upd_cancel),
    .span_cyc(upd_span),
    .active(upd_active)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    run_rise = 1'b0;
    tmr_evt = 1'b0;
    upd_evt = 1'b0;

    // write completing the run bit change starts the count here
    run_rise = reg_wr && (reg_addr == `RTCPI_ADDR_CTRL1) &&
               reg_wdata[`RTCPI_BIT_RUN] && !countdown_run_bit;

    tmr_evt = countdown_run_bit && timer_src_tick && (s_q.cnt == CNT_W'(1));

    // update ticks keep running whatever the mask says
    if (!ctrl_reset_bit) begin
      if (tick_period_choice == TICK_MINUTE) begin
        upd_evt = minute_tick;
      end else begin
        upd_evt = second_tick;
      end
    end

    // register writes
    if (reg_wr) begin
      if (reg_addr == `RTCPI_ADDR_CTRL1) begin
        s_d.ctrl1 = reg_wdata;
      end else if (reg_addr == `RTCPI_ADDR_FLAGS) begin
        // zero clears, one is ignored
        s_d.clock_tick_flag = s_q.clock_tick_flag && reg_wdata[`RTCPI_BIT_TICK_FLAG];
        s_d.countdown_hit_flag = s_q.countdown_hit_flag && reg_wdata[`RTCPI_BIT_HIT_FLAG];
      end else if (reg_addr == `RTCPI_ADDR_CTRL2) begin
        s_d.ctrl2 = reg_wdata & `RTCPI_CTRL2_WMASK;
      end
    end

    // countdown
    if (run_rise) begin
      s_d.cnt = preset_value;
    end else if (!countdown_run_bit) begin
      // stopped counter sits at the preset
      s_d.cnt = preset_value;
    end else if (timer_src_tick) begin
      if (s_q.cnt == CNT_W'(1)) begin
        s_d.cnt = preset_value;
      end else if (s_q.cnt != '0) begin
        s_d.cnt = s_q.cnt - CNT_W'(1);
      end
    end

    // set wins over a clear in the same cycle
    if (tmr_evt) begin
      s_d.countdown_hit_flag = 1'b1;
    end
    if (upd_evt) begin
      s_d.clock_tick_flag = 1'b1;
    end

    // reads answer one cycle later, unmapped reads give zero
    s_d.rvalid = reg_rd;
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `RTCPI_ADDR_CTRL1) begin
        s_d.rdata = s_q.ctrl1;
      end else if (reg_addr == `RTCPI_ADDR_FLAGS) begin
        s_d.rdata[`RTCPI_BIT_TICK_FLAG] = s_q.clock_tick_flag;
        s_d.rdata[`RTCPI_BIT_HIT_FLAG] = s_q.countdown_hit_flag;
      end else if (reg_addr == `RTCPI_ADDR_CTRL2) begin
        s_d.rdata = s_q.ctrl2;
      end
    end

    // shared line: either enabled source in its span pulls low
    s_d.oe_n = !((tmr_active && countdown_irq_mask) ||
                 (upd_active && clock_tick_irq_mask));
    s_d.pin_lvl = 1'b0;
    s_d.wk_evt = tmr_evt;
    s_d.up_evt = upd_evt;
    // pad readback arrives from the board, so it passes two flops first
    s_d.pin_s1 = irq_n_in;
    s_d.pin_s2 = s_q.pin_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.ctrl1 <= `RTCPI_CTRL1_RESET;
      s_q.ctrl2 <= `RTCPI_CTRL2_RESET;
      s_q.clock_tick_flag <= 1'b0;
      s_q.countdown_hit_flag <= 1'b0;
      s_q.cnt <= '0;
      s_q.rdata <= 8'h00;
      s_q.rvalid <= 1'b0;
      s_q.oe_n <= 1'b1;
      s_q.pin_lvl <= 1'b0;
      s_q.wk_evt <= 1'b0;
      s_q.up_evt <= 1'b0;
      // released line idles at the pull-up level
      s_q.pin_s1 <= 1'b1;
      s_q.pin_s2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign irq_n_out = s_q.pin_lvl;
  // one cycle of latency after a mask clear, traded for a flopped pin
  assign irq_oe_n = s_q.oe_n;
  assign wakeup_event = s_q.wk_evt;
  assign update_event = s_q.up_evt;

  ////////////////////////////////////////////////////////////////////////
  // checks

  // countdown source
  a_run_start: assert property (@(posedge clk) disable iff (rst)
    run_rise |=> (s_q.cnt == $past(preset_value))) else $error("countdown did not load preset");

  a_cnt_step: assert property (@(posedge clk) disable iff (rst)
    (countdown_run_bit && timer_src_tick && s_q.cnt > CNT_W'(1) && !run_rise)
    |=> (s_q.cnt == $past(s_q.cnt) - CNT_W'(1))) else $error("countdown did not step");

  a_cnt_hold: assert property (@(posedge clk) disable iff (rst)
    (countdown_run_bit && !timer_src_tick && !run_rise) |=> $stable(s_q.cnt))
    else $error("countdown moved without a source tick");

  a_cnt_reload: assert property (@(posedge clk) disable iff (rst)
    tmr_evt |=> (s_q.cnt == $past(preset_value)) ##0 wakeup_event) else $error("no reload after event");

  a_hit_flag: assert property (@(posedge clk) disable iff (rst)
    tmr_evt |=> s_q.countdown_hit_flag [*1] ##1 1'b1) else $error("hit flag not set");

  a_hit_hold: assert property (@(posedge clk) disable iff (rst)
    (s_q.countdown_hit_flag && !(reg_wr && reg_addr == `RTCPI_ADDR_FLAGS))
    |=> s_q.countdown_hit_flag) else $error("hit flag dropped");

  a_hit_ign1: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == `RTCPI_ADDR_FLAGS && reg_wdata[`RTCPI_BIT_HIT_FLAG] && !tmr_evt)
    |=> (s_q.countdown_hit_flag == $past(s_q.countdown_hit_flag))) else $error("hit flag set by write");

  a_wk_masked: assert property (@(posedge clk) disable iff (rst)
    (tmr_evt && !countdown_irq_mask) |=> !tmr_active) else $error("masked wakeup started span");

  a_wk_drive: assert property (@(posedge clk) disable iff (rst)
    (tmr_evt && countdown_irq_mask) ##1 (countdown_irq_mask && countdown_run_bit) |=> !irq_oe_n)
    else $error("wakeup did not pull line");

  a_span_idle: assert property (@(posedge clk) disable iff (rst)
    (!tmr_active && !upd_active) |=> irq_oe_n) else $error("line low with no span running");

  a_cd_release: assert property (@(posedge clk) disable iff (rst)
    (!countdown_irq_mask && !(upd_active && clock_tick_irq_mask)) |=> irq_oe_n)
    else $error("line held after countdown mask cleared");

  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    (!countdown_run_bit && !reg_wr) |=> (!tmr_active && s_q.cnt == $past(preset_value)))
    else $error("stopped timer still active");

  // update source
  a_tick_sel: assert property (@(posedge clk) disable iff (rst)
    ((tick_period_choice == TICK_MINUTE) ? !minute_tick : !second_tick) |-> !upd_evt)
    else $error("update without its selected tick");

  a_tick_block: assert property (@(posedge clk) disable iff (rst)
    ctrl_reset_bit |-> !upd_evt) else $error("update event under reset bit");

  a_tick_flag: assert property (@(posedge clk) disable iff (rst)
    upd_evt |=> (s_q.clock_tick_flag && update_event)) else $error("tick flag not set");

  a_tick_hold: assert property (@(posedge clk) disable iff (rst)
    (s_q.clock_tick_flag && !(reg_wr && reg_addr == `RTCPI_ADDR_FLAGS))
    |=> s_q.clock_tick_flag) else $error("tick flag dropped");

  a_tick_ign1: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == `RTCPI_ADDR_FLAGS && reg_wdata[`RTCPI_BIT_TICK_FLAG] && !upd_evt)
    |=> (s_q.clock_tick_flag == $past(s_q.clock_tick_flag))) else $error("tick flag set by write");

  a_upd_drive: assert property (@(posedge clk) disable iff (rst)
    (upd_evt && clock_tick_irq_mask) ##1 clock_tick_irq_mask |=> !irq_oe_n)
    else $error("update did not pull line");

  a_upd_masked: assert property (@(posedge clk) disable iff (rst)
    (upd_evt && !clock_tick_irq_mask) |=> !upd_active) else $error("masked update started span");

  a_upd_release: assert property (@(posedge clk) disable iff (rst)
    (!clock_tick_irq_mask && !(tmr_active && countdown_irq_mask)) |=> irq_oe_n)
    else $error("line held after tick mask cleared");

  // shared line and register view
  // the line is the or of both sources, judged one cycle behind them
  a_line_src: assert property (@(posedge clk) disable iff (rst)
    !irq_oe_n |-> $past((tmr_active && countdown_irq_mask) || (upd_active && clock_tick_irq_mask)))
    else $error("line low without an enabled source");

  // readback only feeds this check; another device may also hold the line low
  a_pin_sense: assert property (@(posedge clk) disable iff (rst)
    ($past(irq_oe_n, 2) == 1'b0) |-> !s_q.pin_s2) else $error("driven line not seen low");

  a_zero_bits: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == `RTCPI_ADDR_FLAGS) |=>
    (reg_rdata[7:6] == 2'b00 && reg_rdata[3:0] == 4'h0)) else $error("fixed zero bit read one");

  a_ctrl2_zero: assert property (@(posedge clk) disable iff (rst)
    1'b1 |-> (s_q.ctrl2[2:1] == 2'b00)) else $error("fixed zero control bit set");

endmodule // rtcpi_top

// File: verif/rtcpi_host_model.sv
// Purpose: host side of the shared open-drain interrupt line
// Assumes: the line carries a pull-up; the device can only pull it low
// Notes: the resolved level is also fed back to the device readback pin
`timescale 1ns/100ps

module rtcpi_host_model (
  // device pin
  input wire logic irq_n_out,
  input wire logic irq_oe_n,
  // level the host sees
  output logic irq_line
);
  // a released pin must read as the pull-up, never as the last driven value
  assign irq_line = irq_oe_n ? 1'b1 : irq_n_out;
endmodule // rtcpi_host_model

// File: verif/rtc_periodic_irq_logic_tb.sv
// Purpose: self-checking bench of the periodic interrupt logic
// Assumes: ticks and strobes are one-cycle pulses driven 1 ns after the edge
// Notes: spans are shortened to 30 and 12 cycles to keep the run brief
`timescale 1ns/100ps
`include "rtcpi_cfg.svh"

module rtc_periodic_irq_logic_tb;
  import rtcpi_pkg::*;
  localparam int LONG_C = 30;
  localparam int SHORT_C = 12;
  logic clk, rst, reg_wr, reg_rd, reg_rvalid, timer_src_tick, second_tick, minute_tick;
  logic irq_n_out, irq_oe_n, irq_line, wakeup_event, update_event;
  rtcpi_byte_t reg_addr, reg_wdata, reg_rdata;
  logic [`RTCPI_CNT_W-1:0] preset_value;
  int miscompares = 0;
  int n_compared = 0;

  rtcpi_top #(.CNT_W(`RTCPI_CNT_W), .SPAN_LONG_CYC(LONG_C), .SPAN_SHORT_CYC(SHORT_C)) dut_u (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .preset_value(preset_value), .timer_src_tick(timer_src_tick), .second_tick(second_tick),
    .minute_tick(minute_tick), .irq_n_in(irq_line), .irq_n_out(irq_n_out), .irq_oe_n(irq_oe_n),
    .wakeup_event(wakeup_event), .update_event(update_event));
  rtcpi_host_model host_u (.irq_n_out(irq_n_out), .irq_oe_n(irq_oe_n), .irq_line(irq_line));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(rtcpi_byte_t a, rtcpi_byte_t d);
    step(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
  endtask

  // answer stands one cycle only, so it is taken right after the strobe edge
  task automatic rd(rtcpi_byte_t a, rtcpi_byte_t exp, string what);
    step(1);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    chk({what, " valid"}, reg_rvalid, 32'h1);
    chk(what, reg_rdata, exp);
  endtask

  // 0 countdown source, 1 second rollover, 2 minute rollover
  task automatic tick(int which);
    step(1);
    timer_src_tick = (which == 0);
    second_tick = (which == 1);
    minute_tick = (which == 2);
    step(1);
    timer_src_tick = 1'b0;
    second_tick = 1'b0;
    minute_tick = 1'b0;
  endtask

  task automatic low_span(int exp, string what);
    int n;
    n = 0;
    while (irq_line === 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      report_and_stop();
    end else begin
      chk(what, n, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    rd(`RTCPI_ADDR_CTRL1, 8'h00, "ctrl1 reset");
    rd(`RTCPI_ADDR_CTRL2, 8'h40, "ctrl2 reset");
    rd(`RTCPI_ADDR_FLAGS, 8'h00, "flags reset");
    rd(8'h10, 8'h00, "unmapped read");
    chk("line idle", irq_line, 32'h1);
    wr(`RTCPI_ADDR_CTRL2, 8'hff);
    rd(`RTCPI_ADDR_CTRL2, 8'hf9, "ctrl2 fixed zeros");
    wr(`RTCPI_ADDR_CTRL2, 8'h00);
  endtask

  task automatic sc_countdown();
    preset_value = 24'h000003;
    wr(`RTCPI_ADDR_CTRL2, 8'h10);
    wr(`RTCPI_ADDR_CTRL1, 8'h10);
    for (int k = 1; k <= 3; k++) begin
      tick(0);
      chk("wakeup first run", wakeup_event, k == 3);
    end
    step(1);
    chk("line low on wakeup", irq_line, 32'h0);
    chk("pin drive value", irq_n_out, 32'h0);
    low_span(LONG_C, "wakeup long span");
    rd(`RTCPI_ADDR_FLAGS, 8'h10, "hit flag set");
    for (int k = 1; k <= 3; k++) begin
      tick(0);
      chk("wakeup reload run", wakeup_event, k == 3);
    end
    step(1);
    chk("line low again", irq_line, 32'h0);
    wr(`RTCPI_ADDR_FLAGS, 8'h00);
    step(2);
    chk("line after hit clear", irq_line, 32'h0);
    rd(`RTCPI_ADDR_FLAGS, 8'h00, "hit flag cleared");
    wr(`RTCPI_ADDR_CTRL2, 8'h00);
    step(2);
    chk("line after mask clear", irq_line, 32'h1);
    for (int k = 1; k <= 3; k++) begin
      tick(0);
      chk("wakeup masked run", wakeup_event, k == 3);
    end
    step(1);
    chk("line masked wakeup", irq_line, 32'h1);
  endtask

  task automatic sc_stop();
    wr(`RTCPI_ADDR_CTRL1, 8'h00);
    preset_value = 24'h000001;
    wr(`RTCPI_ADDR_CTRL2, 8'h10);
    wr(`RTCPI_ADDR_CTRL1, 8'h30);
    tick(0);
    chk("wakeup preset one", wakeup_event, 32'h1);
    step(1);
    low_span(SHORT_C, "wakeup short span");
    tick(0);
    step(1);
    chk("line before stop", irq_line, 32'h0);
    wr(`RTCPI_ADDR_CTRL1, 8'h00);
    step(2);
    chk("line after stop", irq_line, 32'h1);
    tick(0);
    chk("wakeup after stop", wakeup_event, 32'h0);
  endtask

  task automatic sc_update();
    // hit flag is still set from the stop scenario
    wr(`RTCPI_ADDR_FLAGS, 8'h00);
    wr(`RTCPI_ADDR_CTRL2, 8'h20);
    tick(1);
    chk("second update", update_event, 32'h1);
    step(1);
    low_span(SHORT_C, "update span");
    rd(`RTCPI_ADDR_FLAGS, 8'h20, "tick flag set");
    wr(`RTCPI_ADDR_FLAGS, 8'hff);
    rd(`RTCPI_ADDR_FLAGS, 8'h20, "flags write ones");
    wr(`RTCPI_ADDR_FLAGS, 8'h00);
    rd(`RTCPI_ADDR_FLAGS, 8'h00, "tick flag zeroed");
    wr(`RTCPI_ADDR_FLAGS, 8'hff);
    rd(`RTCPI_ADDR_FLAGS, 8'h00, "flags stay clear on ones");
  endtask

  task automatic sc_minute();
    wr(`RTCPI_ADDR_CTRL2, 8'h00);
    wr(`RTCPI_ADDR_CTRL1, 8'h20);
    wr(`RTCPI_ADDR_CTRL2, 8'h20);
    tick(1);
    chk("second in minute mode", update_event, 32'h0);
    tick(2);
    chk("minute update", update_event, 32'h1);
    wr(`RTCPI_ADDR_FLAGS, 8'h00);
    step(2);
    chk("line after tick clear", irq_line, 32'h0);
    wr(`RTCPI_ADDR_CTRL2, 8'h00);
    step(2);
    chk("line after tick mask", irq_line, 32'h1);
    tick(2);
    chk("masked update runs", update_event, 32'h1);
    step(1);
    chk("line masked update", irq_line, 32'h1);
    rd(`RTCPI_ADDR_FLAGS, 8'h20, "masked flag set");
    wr(`RTCPI_ADDR_FLAGS, 8'h00);
    wr(`RTCPI_ADDR_CTRL2, 8'h01);
    tick(2);
    chk("update in reset", update_event, 32'h0);
    rd(`RTCPI_ADDR_FLAGS, 8'h00, "flag in reset");
  endtask

  task automatic sc_shared();
    wr(`RTCPI_ADDR_CTRL1, 8'h00);
    preset_value = 24'h000001;
    wr(`RTCPI_ADDR_CTRL2, 8'h30);
    wr(`RTCPI_ADDR_CTRL1, 8'h10);
    tick(0);
    tick(1);
    wr(`RTCPI_ADDR_CTRL2, 8'h20);
    step(2);
    chk("line held by update", irq_line, 32'h0);
    low_span(9, "shared remaining span");
    wr(`RTCPI_ADDR_CTRL1, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    preset_value = '0;
    timer_src_tick = 1'b0;
    second_tick = 1'b0;
    minute_tick = 1'b0;
    step(10);
    rst = 1'b0;
    sc_reset();
    sc_countdown();
    sc_stop();
    sc_update();
    sc_minute();
    sc_shared();
    report_and_stop();
  end
endmodule // rtc_periodic_irq_logic_tb
